// ---- usb_bd_pkg.sv ----
// ---------------------------------------------------------------
// constants shared by the buffer descriptor engine
// ---------------------------------------------------------------
// assumes an apb master on pclk and a serial engine that delivers
// tokens, receive bytes and accepts transmit bytes on the same clock
// Contract
// - descriptor slot from endpoint, direction, even/odd
// - ownership zero means descriptor is ignored
// - move data to/from pointed buffer
// - completion writes back, clears ownership
// - store token pid in control byte
// - data0/1 bit kept unchanged
// - toggle sync bit enables toggle checking
// - stall bit answers stall, descriptor untouched
// - receive completion overwrites byte count
// - packets capped at sixty-four bytes
// - buffer pointer is 16-byte aligned, unaltered
// - token acceptance updates status, completion sets token flag
// - latency overrun answers nak/timeout, sets error
// - error interrupt gated by both enable registers
// - latency overrun skips write-back and token flag
// - oversized packet still acknowledged
// - oversized data clipped, count equals maximum
// - oversized sets buffer flag, pid never 1111
// - descriptor table layout at ram 0x00..0x1D
package usb_bd_pkg;
	// apb register byte addresses
	localparam logic [7:0] INT_STAT_ADDR = 8'h00;
	localparam logic [7:0] INT_EN_ADDR = 8'h04;
	localparam logic [7:0] ERR_STAT_ADDR = 8'h08;
	localparam logic [7:0] ERR_EN_ADDR = 8'h0C;
	localparam logic [7:0] STAT_ADDR = 8'h10;
	localparam logic [7:0] MAXP_ADDR = 8'h14;
	// descriptor byte offsets and control byte fields
	localparam logic [9:0] BD_CTL_OFS = 10'h000;
	localparam logic [9:0] BD_CNT_OFS = 10'h001;
	localparam logic [9:0] BD_PTR_OFS = 10'h002;
	localparam int OWN_BIT = 7;
	localparam int DATA1_BIT = 6;
	localparam int TOGGLE_BIT = 3;
	localparam int STALL_BIT = 2;
	localparam logic [4:0] BD_SIZE = 5'h03;
	// token pids
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	// handshake answers to the serial engine
	localparam logic [1:0] HS_ACK = 2'h0;
	localparam logic [1:0] HS_NAK = 2'h1;
	localparam logic [1:0] HS_STALL = 2'h2;
	localparam logic [1:0] HS_TIMEOUT = 2'h3;
	// packet size cap and reset values
	localparam logic [6:0] MAX_PKT = 7'h40;
	localparam logic [6:0] MAXP_RESET = 7'h40;
	localparam logic [1:0] EN_RESET = 2'h0;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01, S_RD0 = 8'h02, S_RD1 = 8'h04, S_RD2 = 8'h08,
		S_DATA = 8'h10, S_WB1 = 8'h20, S_WB0 = 8'h40, S_DONE = 8'h80
	} bd_state_t;
endpackage : usb_bd_pkg

// ---- usb_bd_engine.sv ----
// ---------------------------------------------------------------
// buffer descriptor engine: fetches descriptors, moves packet data,
// writes back results and keeps token and error status
// ---------------------------------------------------------------
// assumes a byte-wide local ram answering ram_req with ram_ack, and a
// serial engine that raises tok_valid only while tok_ready is high
//
// Local design decision: the APB slave port.
module usb_bd_engine (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// token from serial engine
	input wire logic tok_valid,
	input wire logic [3:0] tok_pid,
	input wire logic [2:0] tok_ep,
	input wire logic tok_odd,
	output logic tok_ready,
	// receive bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	input wire logic rx_data1,
	// transmit bytes
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic tx_data1,
	input wire logic tx_ready,
	// handshake answer
	output logic hs_valid,
	output logic [1:0] hs_code,
	// local usb ram
	output logic ram_req,
	output logic ram_we,
	output logic [9:0] ram_addr,
	output logic [7:0] ram_wdata,
	input wire logic ram_ack,
	input wire logic [7:0] ram_rdata,
	// interrupt
	output logic irq
);
	import usb_bd_pkg::*;

	typedef struct packed {
		bd_state_t st;
		logic [3:0] pid;
		logic rx;
		logic [4:0] base;
		logic [7:0] cs;
		logic [7:0] bc;
		logic [5:0] ptr;
		logic [6:0] cnt;
		logic [6:0] len;
		logic ovr;
		logic big;
		logic bad_toggle;
		logic ram_req;
		logic ram_we;
		logic [9:0] ram_addr;
		logic [7:0] ram_wdata;
		logic tx_valid;
		logic [7:0] tx_data;
		logic tx_last;
		logic tx_data1;
		logic tok_ready;
		logic hs_valid;
		logic [1:0] hs_code;
		logic tok_flag;
		logic err_buf;
		logic err_bto;
		logic [1:0] int_en;
		logic [1:0] err_en;
		logic [6:0] maxp;
		logic [4:0] stat;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} eng_t;

	eng_t q, d;
	logic [4:0] slot;
	logic wr_acc;
	logic [6:0] lim;
	logic [1:0] err_stat;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// one process builds the whole next state
	always_comb begin
		d = q;
		d.hs_valid = 1'b0;
		wr_acc = psel & penable & q.pready & pwrite;
		lim = (q.maxp > MAX_PKT) ? MAX_PKT : q.maxp;
		// descriptor slot: ep0 in, ep0 out, ep1-4, ep5/6 even-odd
		unique case (tok_ep)
			3'd0: slot = (tok_pid == PID_IN) ? 5'd0 : 5'd1;
			3'd5: slot = tok_odd ? 5'd7 : 5'd6;
			3'd6: slot = tok_odd ? 5'd9 : 5'd8;
			default: slot = 5'(tok_ep) + 5'd1;
		endcase
		// ram handshake completes a pending access
		if (q.ram_req && ram_ack) begin
			d.ram_req = 1'b0;
			d.ram_we = 1'b0;
		end
		unique case (q.st)
			S_IDLE: begin
				if (tok_valid && q.tok_ready) begin
					d.tok_ready = 1'b0;
					d.pid = tok_pid;
					d.rx = (tok_pid != PID_IN);
					d.base = 5'(slot * BD_SIZE);
					d.stat = {tok_ep, tok_pid != PID_IN, tok_odd};
					d.cnt = 7'h00;
					d.ovr = 1'b0;
					d.big = 1'b0;
					d.bad_toggle = 1'b0;
					d.ram_req = 1'b1;
					d.ram_addr = 10'(d.base) + BD_CTL_OFS;
					d.st = S_RD0;
				end
			end
			S_RD0: begin
				if (q.ram_req && ram_ack) begin
					d.cs = ram_rdata;
					if (!ram_rdata[OWN_BIT]) begin
						// not owned: nothing else is looked at
						d.hs_valid = 1'b1;
						d.hs_code = HS_NAK;
						d.tok_ready = 1'b1;
						d.st = S_IDLE;
					end else if (ram_rdata[STALL_BIT]) begin
						// stall leaves the descriptor as it was
						d.hs_valid = 1'b1;
						d.hs_code = HS_STALL;
						d.tok_ready = 1'b1;
						d.st = S_IDLE;
					end else begin
						d.ram_req = 1'b1;
						d.ram_addr = 10'(q.base) + BD_CNT_OFS;
						d.st = S_RD1;
					end
				end
			end
			S_RD1: begin
				if (q.ram_req && ram_ack) begin
					d.bc = ram_rdata;
					d.len = (ram_rdata > 8'(lim)) ? lim : 7'(ram_rdata);
					d.ram_req = 1'b1;
					d.ram_addr = 10'(q.base) + BD_PTR_OFS;
					d.st = S_RD2;
				end
			end
			S_RD2: begin
				if (q.ram_req && ram_ack) begin
					d.ptr = ram_rdata[7:2];
					d.tx_data1 = q.cs[DATA1_BIT];
					d.st = S_DATA;
					if (!q.rx && q.len != 7'h00) begin
						d.ram_req = 1'b1;
						d.ram_addr = {ram_rdata[7:2], 4'h0};
					end else if (!q.rx) begin
						d.tx_valid = 1'b1;
						d.tx_last = 1'b1;
					end
				end
			end
			S_DATA: begin
				if (!q.rx) begin
					// transmit: fetch a byte, hand it on, fetch the next
					if (q.ram_req && ram_ack) begin
						d.tx_valid = 1'b1;
						d.tx_data = ram_rdata;
						d.tx_last = (q.cnt + 7'h01 == q.len);
						d.cnt = q.cnt + 7'h01;
					end
					if (q.tx_valid && tx_ready) begin
						d.tx_valid = 1'b0;
						d.tx_last = 1'b0;
						if (q.tx_last) begin
							d.st = S_WB1;
						end else begin
							d.ram_req = 1'b1;
							d.ram_addr = {q.ptr, 4'h0} + 10'(q.cnt);
						end
					end
				end else begin
					// receive: a byte arriving while the last write waits
					// is a latency overrun
					if (rx_valid) begin
						if (q.ram_req && !ram_ack) begin
							d.ovr = 1'b1;
						end else if (q.cnt >= lim) begin
							d.big = 1'b1; // clip excess bytes
						end else begin
							d.ram_req = 1'b1;
							d.ram_we = 1'b1;
							d.ram_addr = {q.ptr, 4'h0} + 10'(q.cnt);
							d.ram_wdata = rx_data;
							d.cnt = q.cnt + 7'h01;
						end
					end
					if (rx_end) begin
						d.bad_toggle = q.cs[TOGGLE_BIT] &
							(rx_data1 != q.cs[DATA1_BIT]);
						d.st = S_WB1;
					end
				end
			end
			S_WB1: begin
				// wait for the last data write before deciding
				if (!q.ram_req || ram_ack) begin
					if (q.rx && q.ovr) begin
						d.hs_valid = 1'b1;
						d.hs_code = (q.pid == PID_SETUP) ? HS_TIMEOUT
							: HS_NAK;
						d.err_bto = 1'b1; // no write-back
						d.tok_ready = 1'b1;
						d.st = S_IDLE;
					end else if (q.rx && q.bad_toggle) begin
						// repeated packet: acknowledge, keep descriptor
						d.hs_valid = 1'b1;
						d.hs_code = HS_ACK;
						d.tok_ready = 1'b1;
						d.st = S_IDLE;
					end else begin
						if (q.rx) begin
							d.hs_valid = 1'b1;
							d.hs_code = HS_ACK;
						end
						d.err_buf = q.err_buf | q.big;
						d.ram_req = 1'b1;
						d.ram_we = 1'b1;
						d.ram_addr = 10'(q.base) + BD_CNT_OFS;
						d.ram_wdata = q.rx ? 8'(q.cnt) : q.bc;
						d.st = S_WB0;
					end
				end
			end
			S_WB0: begin
				// control byte goes last so ownership drops after count
				if (q.ram_req && ram_ack) begin
					d.ram_req = 1'b1;
					d.ram_we = 1'b1;
					d.ram_addr = 10'(q.base) + BD_CTL_OFS;
					d.ram_wdata = {1'b0, q.cs[DATA1_BIT], q.pid, 2'b00};
					d.st = S_DONE;
				end
			end
			S_DONE: begin
				if (q.ram_req && ram_ack) begin
					d.tok_flag = 1'b1;
					d.tok_ready = 1'b1;
					d.st = S_IDLE;
				end
			end
			default: begin
				d.st = S_IDLE;
				d.tok_ready = 1'b1;
			end
		endcase
		// apb: no wait states, answer raised in the first access cycle
		d.pready = psel & ~penable;
		d.pslverr = 1'b0;
		if (psel && !penable) begin
			d.prdata = 32'h0000_0000;
			unique case (paddr)
				INT_STAT_ADDR: d.prdata[1:0] = {|err_stat, q.tok_flag};
				INT_EN_ADDR: d.prdata[1:0] = q.int_en;
				ERR_STAT_ADDR: d.prdata[1:0] = err_stat;
				ERR_EN_ADDR: d.prdata[1:0] = q.err_en;
				STAT_ADDR: d.prdata[4:0] = q.stat;
				MAXP_ADDR: d.prdata[6:0] = q.maxp;
				default: d.pslverr = 1'b1;
			endcase
		end
		// register writes; flag clears lose to a same-cycle set
		if (wr_acc) begin
			unique case (paddr)
				INT_STAT_ADDR: begin
					if (pwdata[0] && !(d.tok_flag && !q.tok_flag)) begin
						d.tok_flag = 1'b0;
					end
				end
				INT_EN_ADDR: d.int_en = pwdata[1:0];
				ERR_STAT_ADDR: begin
					if (pwdata[0] && !(d.err_buf && !q.err_buf)) begin
						d.err_buf = 1'b0;
					end
					if (pwdata[1] && !(d.err_bto && !q.err_bto)) begin
						d.err_bto = 1'b0;
					end
				end
				ERR_EN_ADDR: d.err_en = pwdata[1:0];
				MAXP_ADDR: d.maxp = pwdata[6:0];
				default: d.maxp = q.maxp;
			endcase
		end
		// interrupt from token flag and enabled errors
		d.irq = (d.tok_flag & d.int_en[0]) |
			((|({d.err_bto, d.err_buf} & d.err_en)) & d.int_en[1]);
	end

	assign err_stat = {q.err_bto, q.err_buf};

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// all state held in one register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= S_IDLE;
			q.tok_ready <= 1'b1;
			q.maxp <= MAXP_RESET;
			q.int_en <= EN_RESET;
			q.err_en <= EN_RESET;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign tok_ready = q.tok_ready;
	assign tx_valid = q.tx_valid;
	assign tx_data = q.tx_data;
	assign tx_last = q.tx_last;
	assign tx_data1 = q.tx_data1;
	assign hs_valid = q.hs_valid;
	assign hs_code = q.hs_code;
	assign ram_req = q.ram_req;
	assign ram_we = q.ram_we;
	assign ram_addr = q.ram_addr;
	assign ram_wdata = q.ram_wdata;
	assign irq = q.irq;
endmodule : usb_bd_engine

// ---- usb_ram_model.sv ----
// ---------------------------------------------------------------
// local usb ram model on the descriptor side of the engine
// ---------------------------------------------------------------
// assumes the engine holds ram_req until ram_ack; slow adds latency
module usb_ram_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// ram request
	input wire logic ram_req,
	input wire logic ram_we,
	input wire logic [9:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	input wire logic slow,
	// ram answer
	output logic ram_ack,
	output logic [7:0] ram_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:1023];
	logic [2:0] wait_q;
	// one access per request, data idles inverted between answers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_ack <= 1'b0;
			wait_q <= 3'h0;
			ram_rdata <= 8'h00;
		end else begin
			ram_ack <= 1'b0;
			ram_rdata <= ~ram_rdata;
			if (ram_req && !ram_ack) begin
				if (wait_q < (slow ? 3'h3 : 3'h0)) begin
					wait_q <= wait_q + 3'h1;
				end else begin
					wait_q <= 3'h0;
					ram_ack <= 1'b1;
					if (ram_we) mem[ram_addr] <= ram_wdata;
					else ram_rdata <= mem[ram_addr];
				end
			end
		end
	end
endmodule : usb_ram_model

// ---- usb_bd_engine_sva.sv ----
// ---------------------------------------------------------------
// port checker for the descriptor engine
// ---------------------------------------------------------------
// assumes one pclk domain, bound to usb_bd_engine
module usb_bd_engine_sva
	import usb_bd_pkg::*;
(
	// observed ports
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic tok_valid,
	input wire logic tok_ready,
	input wire logic [3:0] tok_pid,
	input wire logic [2:0] tok_ep,
	input wire logic tok_odd,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic hs_valid,
	input wire logic ram_req,
	input wire logic ram_we,
	input wire logic [9:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	input wire logic ram_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// table byte address of the descriptor a token selects
	function automatic logic [9:0] bd_at(logic [2:0] ep, logic [3:0] pid,
		logic odd);
		logic [9:0] s;
		if (ep == 3'h0) s = (pid == PID_IN) ? 10'h000 : 10'h001;
		else if (ep < 3'h5) s = 10'(ep) + 10'h001;
		else s = (ep == 3'h5 ? 10'h006 : 10'h008) + 10'(odd);
		return s * 10'h003;
	endfunction : bd_at
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("apb access not answered at once");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_unmapped_zero: assert property (pslverr |-> pready && prdata == 0)
		else $error("slave error without ready or zero data");
	chk_desc_fetch: assert property (tok_valid && tok_ready |=>
		!tok_ready && ram_req && !ram_we &&
		ram_addr == bd_at($past(tok_ep), $past(tok_pid), $past(tok_odd)))
		else $error("descriptor fetch address wrong");
	chk_ram_hold: assert property (ram_req && !ram_ack |=> ram_req &&
		$stable(ram_addr) && $stable(ram_we) && $stable(ram_wdata))
		else $error("ram request changed before ack");
	chk_ptr_kept: assert property (ram_req && ram_we &&
		ram_addr < 10'h01E |-> ram_addr % 3 != 2)
		else $error("buffer pointer byte written");
	chk_wb_ctl: assert property (ram_req && ram_we && ram_addr < 10'h01E &&
		ram_addr % 3 == 0 |-> !ram_wdata[OWN_BIT] &&
		ram_wdata[1:0] == 2'h0 && ram_wdata[5:2] != 4'hF)
		else $error("control byte write-back malformed");
	chk_hs_pulse: assert property (hs_valid |=> !hs_valid)
		else $error("handshake longer than one cycle");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
		$stable(tx_data) && $stable(tx_last))
		else $error("transmit byte changed before taken");
endmodule : usb_bd_engine_sva

bind usb_bd_engine usb_bd_engine_sva u_usb_bd_engine_sva (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .prdata, .tok_valid, .tok_ready,
	.tok_pid, .tok_ep, .tok_odd, .tx_valid, .tx_ready, .tx_data, .tx_last,
	.hs_valid, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ack);

// ---- usb_bd_engine_tb.sv ----
// ---------------------------------------------------------------
// testbench: apb, token, receive and transmit sequences
// ---------------------------------------------------------------
// assumes usb_bd_pkg and the ram model are compiled first
module usb_bd_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import usb_bd_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0, rx_data = 0, tx_data, ram_wdata, ram_rdata;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, e, tok_ready, tx_valid, tx_last, tx_data1;
	logic tok_valid = 0, tok_odd = 0, rx_valid = 0, rx_end = 0;
	logic rx_data1 = 0, tx_ready = 0, tx_en = 0, slow = 0, last_q = 0;
	logic flip = 0;
	logic [3:0] tok_pid = 0;
	logic [2:0] tok_ep = 0;
	logic [1:0] hs_code, hs_last = 0;
	logic hs_valid, ram_req, ram_we, ram_ack, irq;
	logic [9:0] ram_addr;
	logic [7:0] txq [$];
	int n_errors = 0, comparisons = 0, cyc = 0, hs_cnt = 0, maxp = 64;
	initial forever #12.5 pclk = ~pclk;
	usb_bd_engine u_usb_bd_engine (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tok_valid,
		.tok_pid, .tok_ep, .tok_odd, .tok_ready, .rx_valid, .rx_data, .rx_end,
		.rx_data1, .tx_valid, .tx_data, .tx_last, .tx_data1, .tx_ready,
		.hs_valid, .hs_code, .ram_req, .ram_we, .ram_addr, .ram_wdata,
		.ram_ack, .ram_rdata, .irq);
	usb_ram_model u_usb_ram_model (.pclk, .presetn, .ram_req, .ram_we,
		.ram_addr, .ram_wdata, .slow, .ram_ack, .ram_rdata);
	// monitors: handshakes, transmitted bytes, stalling far side, timeout
	always @(posedge pclk) begin
		if (hs_valid === 1'b1) begin
			hs_cnt <= hs_cnt + 1;
			hs_last <= hs_code;
		end
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			txq.push_back(tx_data);
			last_q <= tx_last;
		end
		tx_ready <= tx_en ? ~tx_ready : 1'b0;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("counts: %0d mismatches, %0d compares", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		comparisons++;
		if (g !== x) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic tok(input logic [3:0] p, input logic [2:0] ep,
		input logic o);
		@(posedge pclk);
		tok_valid <= 1;
		tok_pid <= p;
		tok_ep <= ep;
		tok_odd <= o;
		do @(posedge pclk); while (tok_ready !== 1'b1);
		tok_valid <= 0;
	endtask : tok
	task automatic wait_idle();
		repeat (3) @(posedge pclk);
		while (tok_ready !== 1'b1) @(posedge pclk);
		@(posedge pclk);
	endtask : wait_idle
	// out/setup token: descriptor, bytes, then every field compared
	task automatic run_out(input logic [3:0] p, input logic [2:0] ep,
		input logic o, input int s, input logic [7:0] c, input int n,
		input logic sl);
		int b, k, h0;
		logic [9:0] d, bf;
		logic [7:0] e0, e1;
		logic [1:0] eh;
		logic tg;
		d = 10'(s * 3);
		bf = 10'((s + 2) * 16);
		for (b = 0; b < 16; b++) u_usb_ram_model.mem[bf + b] = 8'h55;
		u_usb_ram_model.mem[d + 1] = 8'h10;
		u_usb_ram_model.mem[d + 2] = 8'((s + 2) * 4);
		u_usb_ram_model.mem[d] = c;
		k = n > maxp ? maxp : n;
		eh = HS_ACK;
		if (!c[OWN_BIT] || sl) eh = HS_NAK;
		if (sl && c[OWN_BIT] && p == PID_SETUP) eh = HS_TIMEOUT;
		if (c[OWN_BIT] && c[STALL_BIT]) eh = HS_STALL;
		// a repeated packet is acknowledged but not written back
		tg = flip && c[TOGGLE_BIT] && eh == HS_ACK;
		e0 = (eh == HS_ACK && !tg) ? {1'b0, c[DATA1_BIT], p, 2'b00} : c;
		e1 = (eh == HS_ACK && !tg) ? 8'(k) : 8'h10;
		// on overrun only the first slow write lands; the second byte arrives while it waits
		if (eh != HS_ACK) k = (sl && eh != HS_STALL && c[OWN_BIT]) ? 1 : 0;
		slow <= sl;
		h0 = hs_cnt;
		tok(p, ep, o);
		// slow ram needs fifteen cycles for the three descriptor reads
		repeat (16) @(posedge pclk);
		for (b = 0; b < n; b++) begin
			rx_valid <= 1;
			rx_data <= 8'hA0 + 8'(b);
			@(posedge pclk);
			rx_valid <= 0;
			repeat (sl ? 1 : 3) @(posedge pclk);
		end
		rx_end <= 1;
		rx_data1 <= c[DATA1_BIT] ^ flip;
		@(posedge pclk);
		rx_end <= 0;
		wait_idle();
		chk(32'(hs_cnt - h0), 1);
		chk(hs_last, eh);
		chk(u_usb_ram_model.mem[d], e0);
		chk(u_usb_ram_model.mem[d + 1], e1);
		chk(u_usb_ram_model.mem[d + 2], 8'((s + 2) * 4));
		for (b = 0; b < 16; b++)
			chk(u_usb_ram_model.mem[bf + b], b < k ? 8'hA0 + b : 8'h55);
		slow <= 0;
		$display("test out pid %h ep %0d done", p, ep);
	endtask : run_out
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(0, MAXP_ADDR, 0);
		chk(r, 32'h40);
		apb(0, 8'h18, 0);
		chk({e, r}, {1'b1, 32'h0});
		apb(1, INT_EN_ADDR, 1);
		run_out(PID_OUT, 1, 0, 2, 8'hC8, 3, 0);
		chk(irq, 1);
		apb(0, STAT_ADDR, 0);
		chk(r, 32'h06);
		apb(1, INT_STAT_ADDR, 1);
		apb(0, INT_STAT_ADDR, 0);
		chk({irq, r}, 0);
		run_out(PID_SETUP, 0, 0, 1, 8'h80, 2, 0);
		run_out(PID_OUT, 3, 0, 4, 8'h40, 2, 0);
		run_out(PID_OUT, 5, 1, 7, 8'h84, 2, 0);
		flip = 1;
		run_out(PID_OUT, 4, 0, 5, 8'h88, 2, 0);
		run_out(PID_OUT, 4, 0, 5, 8'h80, 2, 0);
		flip = 0;
		apb(1, INT_STAT_ADDR, 1);
		apb(1, INT_EN_ADDR, 2);
		apb(1, ERR_EN_ADDR, 1);
		apb(1, MAXP_ADDR, 4);
		maxp = 4;
		run_out(PID_OUT, 6, 1, 9, 8'h80, 6, 0);
		apb(0, ERR_STAT_ADDR, 0);
		chk({irq, r}, {1'b1, 32'h1});
		apb(1, ERR_STAT_ADDR, 1);
		apb(1, INT_STAT_ADDR, 1);
		run_out(PID_OUT, 2, 0, 3, 8'h80, 3, 1);
		run_out(PID_SETUP, 0, 0, 1, 8'h80, 3, 1);
		apb(0, ERR_STAT_ADDR, 0);
		chk({irq, r}, {1'b0, 32'h2});
		apb(0, INT_STAT_ADDR, 0);
		chk(r[0], 0);
		// in token on endpoint 0 with a stalling receiver
		u_usb_ram_model.mem[0] = 8'hC0;
		u_usb_ram_model.mem[1] = 8'h03;
		u_usb_ram_model.mem[2] = 8'h08;
		for (int b = 0; b < 3; b++) u_usb_ram_model.mem[32 + b] = 8'h11 * (b + 1);
		tx_en <= 1;
		tok(PID_IN, 0, 0);
		wait_idle();
		tx_en <= 0;
		chk(txq.size(), 3);
		for (int b = 0; b < 3; b++) chk(txq[b], 8'h11 * (b + 1));
		chk(last_q, 1);
		chk(tx_data1, 1);
		chk(u_usb_ram_model.mem[0], 8'h64);
		chk(u_usb_ram_model.mem[1], 8'h03);
		$display("test in done");
		finish_test();
	end
endmodule : usb_bd_engine_tb
